// [core/bus_wait_state_controller.sv]
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module bus_wait_state_controller
    import wait_ctrl_pkg::*;
(
    // System
    input wire logic clock,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [WB_ADR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // Bus cycle requests from internal masters
    input wire logic cycle_start,
    input wire cycle_req_t cycle_req,
    input wire logic [AREA_COUNT-1:0] area_hit,
    input wire logic soft_reset,
    // External master
    input wire logic ext_master,
    input wire logic ext_cycle_start,
    // Wait pin, active low
    input wire logic wait_pin_in_n,
    output logic wait_pin_out_n,
    output logic wait_pin_oe,
    // Cycle status
    output bus_state_t bus_state,
    output logic cycle_done,
    output logic access_violation,
    output logic area_code_lo,
    output logic area_code_hi,
    // Refresh controller settings
    output refresh_cfg_t refresh_cfg
);
    // ==========================================
    // Declarations
    logic ack_r; // Bus answer
    logic [31:0] rd_r; // Read data
    logic [15:0] memctl_r; // memory_control_reg
    wire [AREA_COUNT-1:0][15:0] area_words; // All area_wait_reg words
    bus_state_t state_r; // Bus state
    bus_state_t state_nxt;
    logic ext_en_r; // Wait input enable, held for the cycle
    logic ext_out_en_r; // Wait output enable of external cycle area
    logic wait_out_r; // Pin output level
    logic oe_r; // Pin output enable
    logic done_r; // End of cycle pulse
    logic viol_r; // Violation pulse
    logic [1:0] code_r; // Area code
    logic wb_req; // Request present
    logic ack_nxt;
    logic wr_en; // Write at the ack edge
    logic [15:0] wb_idx; // Register index
    logic [2:0] slot; // Area slot of index
    logic [15:0] rd_word;
    logic [1:0] sel_num; // Chosen area
    area_cfg_t sel_cfg; // Its settings
    logic is_special; // Intack or refresh
    logic start_pre;
    logic viol_nxt;
    logic begin_cycle;
    logic [3:0] prog_target;
    logic ext_low; // Enabled external wait
    logic int_pend;
    logic int_last;
    logic ext_load;
    logic ext_pend;
    logic [3:0] ext_target;

    // ==========================================
    // Wishbone slave
    assign wb_req = wb_cyc && wb_stb;
    assign ack_nxt = wb_req && !ack_r;
    assign wr_en = wb_req && wb_we && ack_r;
    assign wb_idx = wb_adr[WB_ADR_W-1:2];
    assign slot = area_slot(wb_idx);

    // One wait cycle answer; ack drops the cycle after it is given
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
        end
    end

    // Read mux; unmapped indices read zero and are acked
    always_comb begin
        rd_word = 16'h0000;
        if (slot[2]) begin
            // Upper byte is never stored, so it reads zero
            rd_word = area_words[slot[1:0]];
        end else if (wb_idx == MEMCTL_IDX) begin
            rd_word = memctl_r;
        end
    end

    // Read data latched with the ack
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_r <= 32'h0000_0000;
        end else if (ack_nxt) begin
            rd_r <= {16'h0000, rd_word};
        end
    end

    // ==========================================
    // Area words, one per area
    for (genvar a = 0; a < AREA_COUNT; a++) begin : g_area
        logic [15:0] word_r;
        // reset to supervisor, hi-z, seven waits
        always_ff @(posedge clock) begin
            if (rst) begin
                word_r <= AREA_WAIT_RESET;
            end else if (wr_en && slot[2] && slot[1:0] == 2'(a)) begin
                word_r <= lane_merge(word_r, wb_dat_w[15:0], wb_sel[1:0]) & AREA_WR_MASK;
            end
        end
        assign area_words[a] = word_r;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            memctl_r <= MEMCTL_RESET;
        end else if (wr_en && wb_idx == MEMCTL_IDX) begin
            memctl_r <= lane_merge(memctl_r, wb_dat_w[15:0], wb_sel[1:0]);
        end
    end

    assign refresh_cfg = '{memctl_r[REF_PRIO_BIT], memctl_r[REF_ON_BIT],
                           memctl_r[REF_EXTRA_LSB+:2], memctl_r[REF_DEFER_LSB+:2],
                           memctl_r[REF_INTERVAL_LSB+:3]};

    // ==========================================
    // Area choice
    // lowest area wins
    // all match at reset so area 0 serves
    area_select u_select (
        .area_hit(area_hit),
        .area_words(area_words),
        .area_num(sel_num),
        .cfg(sel_cfg)
    );

    // ==========================================
    // Cycle start decode
    assign is_special = cycle_req.kind == KIND_INTACK || cycle_req.kind == KIND_REFRESH;
    assign start_pre = cycle_start && state_r == ST_IDLE && !ext_master;
    assign viol_nxt = start_pre && cycle_req.user_level && sel_cfg.supervisor_only
                      && !is_special;
    // A violating access is refused, no bus states run
    assign begin_cycle = start_pre && !viol_nxt;

    // Programmed wait count for this cycle
    always_comb begin
        case (cycle_req.kind)
            KIND_INTACK: prog_target = {2'h0, memctl_r[INTACK_WAIT_LSB+:2]};
            // Refresh waits belong to the refresh controller
            KIND_REFRESH: prog_target = 4'h0;
            default: prog_target = {1'h0, sel_cfg.bus_wait_count};
        endcase
    end

    wait_counter u_int_wait (
        .clock(clock),
        .rst(rst),
        .load(begin_cycle),
        .target(prog_target),
        .step(state_r == ST_WAIT),
        .pending(int_pend),
        .last(int_last)
    );

    assign ext_low = ext_en_r && !wait_pin_in_n;

    // Wait input enable latched so a mid-cycle write cannot split a cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            ext_en_r <= 1'b0;
        end else if (begin_cycle) begin
            ext_en_r <= memctl_r[WAIT_IN_BIT];
        end
    end

    // ==========================================
    // Bus state sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (begin_cycle) begin
                    if (memctl_r[SETUP_BIT] && !cycle_req.internal_ram) begin
                        state_nxt = ST_SETUP;
                    end else begin
                        state_nxt = ST_FIRST;
                    end
                end
            end
            ST_SETUP: state_nxt = ST_FIRST;
            ST_FIRST: state_nxt = ST_SECOND;
            ST_SECOND: begin
                state_nxt = (int_pend || ext_low) ? ST_WAIT : ST_LAST;
            end
            ST_WAIT: begin
                state_nxt = (!int_last || ext_low) ? ST_WAIT : ST_LAST;
            end
            ST_LAST: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // State register; soft reset aborts the cycle only
    always_ff @(posedge clock) begin
        if (rst || soft_reset) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Cycle end and violation pulses
    always_ff @(posedge clock) begin
        if (rst) begin
            done_r <= 1'b0;
            viol_r <= 1'b0;
        end else begin
            done_r <= state_r == ST_LAST;
            viol_r <= viol_nxt;
        end
    end

    // code 11 when no area check is made
    always_ff @(posedge clock) begin
        if (rst) begin
            code_r <= CODE_NONE;
        end else if (begin_cycle) begin
            code_r <= is_special ? CODE_NONE : sel_num;
        end else if (ext_load) begin
            code_r <= sel_num;
        end
    end

    // ==========================================
    // Wait output during bus release
    assign ext_load = ext_cycle_start && ext_master;
    // count plus one; so never below one
    assign ext_target = 4'({1'h0, sel_cfg.bus_wait_count} + 4'h1);

    wait_counter u_ext_wait (
        .clock(clock),
        .rst(rst),
        .load(ext_load),
        .target(ext_target),
        .step(ext_pend),
        .pending(ext_pend),
        .last()
    );

    // Output enable of the area that the external cycle hits
    // cleared on release so a stale enable never drives
    always_ff @(posedge clock) begin
        if (rst) begin
            ext_out_en_r <= 1'b0;
        end else if (ext_load) begin
            ext_out_en_r <= sel_cfg.wait_out_enable;
        end else if (!ext_master) begin
            ext_out_en_r <= 1'b0;
        end
    end

    // input in internal mode, driven only under external master
    // Pin is held high when enabled but idle, so it never floats mid-cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            oe_r <= 1'b0;
            wait_out_r <= 1'b1;
        end else begin
            oe_r <= ext_master && ext_out_en_r;
            wait_out_r <= !(ext_pend && ext_out_en_r);
        end
    end

    // ==========================================
    // Outputs
    assign wb_ack = ack_r;
    assign wb_dat_r = rd_r;
    assign bus_state = state_r;
    assign cycle_done = done_r;
    assign access_violation = viol_r;
    assign area_code_lo = code_r[0];
    assign area_code_hi = code_r[1];
    assign wait_pin_out_n = wait_out_r;
    assign wait_pin_oe = oe_r;

    // ==========================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_reset_vals;
        $past(rst) |-> area_words[0] == AREA_WAIT_RESET && memctl_r == MEMCTL_RESET && !oe_r;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

    property p_violation;
        start_pre && cycle_req.user_level && sel_cfg.supervisor_only && !is_special
            |=> access_violation && state_r == ST_IDLE;
    endproperty
    a_violation: assert property (p_violation) else $error("violation missed");

    property p_special_code;
        begin_cycle && is_special |=> area_code_lo && area_code_hi;
    endproperty
    a_special_code: assert property (p_special_code) else $error("area code not 11");

    property p_setup;
        begin_cycle && memctl_r[SETUP_BIT] && !cycle_req.internal_ram
            |=> state_r == ST_SETUP ##1 state_r == ST_FIRST;
    endproperty
    a_setup: assert property (p_setup) else $error("setup state missing");

    property p_plain_cycle;
        begin_cycle && prog_target == 4'h0 && !memctl_r[WAIT_IN_BIT] && !memctl_r[SETUP_BIT]
            |=> state_r == ST_FIRST ##1 state_r == ST_SECOND ##1 state_r == ST_LAST;
    endproperty
    a_plain_cycle: assert property (p_plain_cycle) else $error("zero wait cycle wrong");

    property p_ext_wait;
        state_r == ST_SECOND && ext_en_r && !wait_pin_in_n |=> state_r == ST_WAIT;
    endproperty
    a_ext_wait: assert property (p_ext_wait) else $error("external wait ignored");

    property p_masked_in;
        state_r == ST_SECOND && !ext_en_r && !int_pend |=> state_r == ST_LAST;
    endproperty
    a_masked_in: assert property (p_masked_in) else $error("masked wait obeyed");

    property p_int_wait;
        state_r == ST_SECOND && int_pend |=> state_r == ST_WAIT;
    endproperty
    a_int_wait: assert property (p_int_wait) else $error("programmed wait missing");

    property p_release_one;
        ext_load && sel_cfg.wait_out_enable && sel_cfg.bus_wait_count == 3'h0
            |=> ##1 !wait_pin_out_n ##1 wait_pin_out_n;
    endproperty
    a_release_one: assert property (p_release_one) else $error("release wait length wrong");

    property p_pin_input;
        !ext_master |=> !wait_pin_oe;
    endproperty
    a_pin_input: assert property (p_pin_input) else $error("pin driven in internal mode");

    property p_pin_hiz;
        ext_load && !sel_cfg.wait_out_enable |=> ##1 !wait_pin_oe;
    endproperty
    a_pin_hiz: assert property (p_pin_hiz) else $error("pin driven with output off");

    property p_priority;
        ext_load && area_hit[0] |=> !area_code_lo && !area_code_hi;
    endproperty
    a_priority: assert property (p_priority) else $error("area priority wrong");

    property p_reserved;
        ack_r && slot[2] |-> wb_dat_r[31:8] == 24'h000000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
endmodule // bus_wait_state_controller

// [core/wait_ctrl_pkg.sv]
// ==========================================
// Constants and types of the wait state controller
package wait_ctrl_pkg;
    // ==========================================
    // Register map: printed offsets are indices, byte address is four times
    localparam int AREA_COUNT = 4;
    localparam int WB_ADR_W = 18;
    localparam logic [15:0] AREA0_IDX = 16'hff2c;
    localparam logic [15:0] AREA1_IDX = 16'hff32;
    localparam logic [15:0] AREA2_IDX = 16'hff38;
    localparam logic [15:0] AREA3_IDX = 16'hff3e;
    localparam logic [15:0] MEMCTL_IDX = 16'hfff8;
    // Reset values and writable bits
    localparam logic [15:0] AREA_WAIT_RESET = 16'h0047;
    localparam logic [15:0] MEMCTL_RESET = 16'hf0e0;
    localparam logic [15:0] AREA_WR_MASK = 16'h00c7;
    // ==========================================
    // Field positions of area_wait_reg
    localparam int WAIT_COUNT_LSB = 0;
    localparam int SUPER_BIT = 6;
    localparam int WAIT_OUT_BIT = 7;
    // Field positions of memory_control_reg
    localparam int WAIT_IN_BIT = 15;
    localparam int SETUP_BIT = 14;
    localparam int INTACK_WAIT_LSB = 12;
    localparam int REF_PRIO_BIT = 11;
    localparam int REF_ON_BIT = 10;
    localparam int REF_EXTRA_LSB = 8;
    localparam int REF_DEFER_LSB = 6;
    localparam int REF_INTERVAL_LSB = 3;
    // Area code when no area check is made or no area 0-2 matched
    localparam logic [1:0] CODE_NONE = 2'h3;
    // ==========================================
    // Types
    typedef enum logic [1:0] {
        KIND_CPU = 2'h0,
        KIND_DMA = 2'h1,
        KIND_REFRESH = 2'h2,
        KIND_INTACK = 2'h3
    } cycle_kind_t;
    typedef struct packed {
        cycle_kind_t kind;
        logic user_level;
        logic internal_ram;
    } cycle_req_t;
    typedef struct packed {
        logic wait_out_enable;
        logic supervisor_only;
        logic [2:0] bus_wait_count;
    } area_cfg_t;
    typedef struct packed {
        logic refresh_priority;
        logic refresh_on;
        logic [1:0] refresh_extra_states;
        logic [1:0] deferred_request_limit;
        logic [2:0] refresh_interval_sel;
    } refresh_cfg_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SETUP = 6'h02,
        ST_FIRST = 6'h04,
        ST_SECOND = 6'h08,
        ST_WAIT = 6'h10,
        ST_LAST = 6'h20
    } bus_state_t;
    // ==========================================
    // Field decode of one area word
    function automatic area_cfg_t area_cfg(input logic [15:0] w);
        area_cfg = '{w[WAIT_OUT_BIT], w[SUPER_BIT], w[WAIT_COUNT_LSB+:3]};
    endfunction
    // Byte lane merge for a 16-bit register
    function automatic logic [15:0] lane_merge(input logic [15:0] old_w,
                                               input logic [15:0] new_w,
                                               input logic [1:0] sel);
        lane_merge = {sel[1] ? new_w[15:8] : old_w[15:8],
                      sel[0] ? new_w[7:0] : old_w[7:0]};
    endfunction
    // Register index to {valid, area number}
    function automatic logic [2:0] area_slot(input logic [15:0] idx);
        case (idx)
            AREA0_IDX: area_slot = 3'h4;
            AREA1_IDX: area_slot = 3'h5;
            AREA2_IDX: area_slot = 3'h6;
            AREA3_IDX: area_slot = 3'h7;
            default: area_slot = 3'h0;
        endcase
    endfunction
endpackage

// [core/area_select.sv]
`timescale 1ns/1ps
// ==========================================
// Priority pick among matching areas
module area_select
    import wait_ctrl_pkg::*;
(
    // Match lines from the comparators
    input wire logic [AREA_COUNT-1:0] area_hit,
    // Stored area words
    input wire logic [AREA_COUNT-1:0][15:0] area_words,
    // Chosen area and its settings
    output logic [1:0] area_num,
    output area_cfg_t cfg
);
    // Lowest number wins; loop runs downward so the last hit kept is lowest
    always_comb begin
        area_num = CODE_NONE;
        for (int i = AREA_COUNT - 1; i >= 0; i--) begin
            if (area_hit[i]) begin
                area_num = 2'(i);
            end
        end
        // No hit falls back to area 3 settings, as code 11 does
        cfg = area_cfg(area_words[area_num]);
    end
endmodule // area_select

// [core/wait_counter.sv]
`timescale 1ns/1ps
// ==========================================
// Down counter of wait states still owed
module wait_counter
    import wait_ctrl_pkg::*;
(
    // System
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic [3:0] target,
    input wire logic step,
    // Status
    output logic pending,
    output logic last
);
    logic [3:0] remaining_r; // States still to insert

    // Load wins over step so a new cycle never inherits old count
    always_ff @(posedge clock) begin
        if (rst) begin
            remaining_r <= 4'h0;
        end else if (load) begin
            remaining_r <= target;
        end else if (step && remaining_r != 4'h0) begin
            remaining_r <= remaining_r - 4'h1;
        end
    end

    assign pending = remaining_r != 4'h0;
    assign last = remaining_r <= 4'h1;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_load_target;
        load |=> remaining_r == $past(target);
    endproperty
    a_load_target: assert property (p_load_target) else $error("counter load wrong");
    property p_step_down;
        step && !load && pending |=> remaining_r == $past(remaining_r) - 4'h1;
    endproperty
    a_step_down: assert property (p_step_down) else $error("counter step wrong");
endmodule // wait_counter

// [testbench/slow_device.sv]
`timescale 1ns/1ps
// ==========================================
// Slow device: pulls the wait pin low for a set number of states
module slow_device
    import wait_ctrl_pkg::*;
(
    // System
    input wire logic clock,
    input wire logic rst,
    // Bus view and wanted stretch
    input wire bus_state_t bus_state,
    input wire logic [3:0] stretch,
    // Wait request, low = wait
    output logic wait_n
);
    logic [3:0] cnt_r; // States spent in second or wait
    // Restart the count at each first bus state
    always_ff @(posedge clock) begin
        if (rst || bus_state == ST_FIRST) begin
            cnt_r <= 4'h0;
        end else if (bus_state == ST_SECOND || bus_state == ST_WAIT) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    // Line has a pull-up, so a released pin reads high
    assign wait_n = !((bus_state == ST_SECOND || bus_state == ST_WAIT) && cnt_r < stretch);
endmodule // slow_device

// [testbench/bus_wait_state_controller_tb.sv]
`timescale 1ns/1ps
// ==========================================
// Bench: register bus, internal cycles, bus release
module bus_wait_state_controller_tb;
    import wait_ctrl_pkg::*;
    typedef struct {logic [15:0] memctl; logic [3:0] hit; logic [1:0] kind;
        logic ram; int st; int len; logic [1:0] code;} row_t;
    logic clock = 0, rst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack;
    logic [17:0] wb_adr = '0;
    logic [3:0] wb_sel = '0, area_hit = '0, stretch = '0;
    logic [31:0] wb_dat_w = '0, wb_dat_r;
    logic cycle_start = 0, soft_reset = 0, ext_master = 0, ext_cycle_start = 0;
    cycle_req_t cycle_req = '0;
    logic dev_n, pin_out_n, pin_oe, wait_line, cycle_done, violation, code_lo, code_hi;
    bus_state_t bus_state;
    refresh_cfg_t refresh_cfg;
    int fails = 0, checks = 0, cyc_cnt = 0;
    logic [15:0] q;
    // Pin level: driven by the controller when enabled, else the device
    assign wait_line = pin_oe ? pin_out_n : dev_n;
    bus_wait_state_controller dut_u (.clock(clock), .rst(rst), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .cycle_start(cycle_start), .cycle_req(cycle_req), .area_hit(area_hit),
        .soft_reset(soft_reset), .ext_master(ext_master), .ext_cycle_start(ext_cycle_start),
        .wait_pin_in_n(wait_line), .wait_pin_out_n(pin_out_n), .wait_pin_oe(pin_oe),
        .bus_state(bus_state), .cycle_done(cycle_done), .access_violation(violation),
        .area_code_lo(code_lo), .area_code_hi(code_hi), .refresh_cfg(refresh_cfg));
    slow_device slow_dev_u (.clock(clock), .rst(rst), .bus_state(bus_state),
        .stretch(stretch), .wait_n(dev_n));
    initial begin
        forever #25 clock = ~clock;
    end
    // Hang guard
    always @(posedge clock) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Classic single cycle; read data taken at the ack edge
    task automatic wb(input logic we, input logic [15:0] idx, input logic [15:0] d);
        wb_cyc <= 1; wb_stb <= 1; wb_we <= we; wb_sel <= 4'h3;
        wb_adr <= {idx, 2'b00}; wb_dat_w <= {16'h0, d};
        do @(posedge clock); while (wb_ack !== 1'b1);
        q = wb_dat_r[15:0];
        wb_cyc <= 0; wb_stb <= 0;
        @(posedge clock);
    endtask
    // Start one internal cycle; len = edges from take to done
    task automatic run(input row_t r, output int len, output logic [1:0] code);
        area_hit <= r.hit; stretch <= r.st[3:0];
        cycle_req <= '{cycle_kind_t'(r.kind), 1'b0, r.ram};
        cycle_start <= 1;
        @(posedge clock);
        cycle_start <= 0;
        len = 0;
        do begin
            @(posedge clock);
            len++;
            if (bus_state === ST_FIRST) code = {code_hi, code_lo};
        end while (cycle_done !== 1'b1 && len < 30);
        @(posedge clock);
    endtask
    // Bus release: count states with the pin driven low
    task automatic ext_run(input logic [15:0] w, input int exp);
        int n;
        int o;
        n = 0;
        o = 0;
        wb(1, AREA0_IDX, w);
        area_hit <= 4'h1; ext_master <= 1;
        @(posedge clock);
        ext_cycle_start <= 1;
        @(posedge clock);
        ext_cycle_start <= 0;
        repeat (12) begin
            @(posedge clock);
            n += (pin_oe === 1'b1 && pin_out_n === 1'b0);
            o += (pin_oe === 1'b1);
        end
        chk("wait low states", n, exp);
        chk("pin driven", o != 0, w[7]);
        ext_master <= 0;
        repeat (3) @(posedge clock);
        chk("pin released", pin_oe, 0);
    endtask
    row_t rows[13] = '{
        '{16'h0000, 4'h1, 2'h0, 0, 0, 6, 2'h0}, '{16'h0000, 4'h2, 2'h0, 0, 0, 9, 2'h1},
        '{16'h0000, 4'h3, 2'h0, 0, 0, 6, 2'h0}, '{16'h0000, 4'h0, 2'h0, 0, 0, 4, 2'h3},
        '{16'h4000, 4'h1, 2'h0, 0, 0, 7, 2'h0}, '{16'h4000, 4'h1, 2'h0, 1, 0, 6, 2'h0},
        '{16'h8000, 4'h1, 2'h0, 0, 5, 9, 2'h0}, '{16'h0000, 4'h1, 2'h0, 0, 5, 6, 2'h0},
        '{16'h8000, 4'h1, 2'h0, 0, 1, 6, 2'h0}, '{16'h2000, 4'h1, 2'h3, 0, 0, 6, 2'h3},
        '{16'hb000, 4'h1, 2'h3, 0, 4, 8, 2'h3}, '{16'h0ff8, 4'h2, 2'h2, 0, 0, 4, 2'h3},
        '{16'h0000, 4'h2, 2'h1, 0, 0, 9, 2'h1}};
    logic [15:0] idx[4] = '{AREA0_IDX, AREA1_IDX, AREA2_IDX, AREA3_IDX};
    // Main sequence
    initial begin
        int len;
        logic [1:0] code;
        repeat (12) @(posedge clock);
        chk("oe in reset", pin_oe, 0);
        chk("out in reset", pin_out_n, 1);
        rst <= 0;
        @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            wb(0, idx[i], 0);
            chk("area word reset", q, AREA_WAIT_RESET);
        end
        wb(0, MEMCTL_IDX, 0);
        chk("mem ctrl reset", q, MEMCTL_RESET);
        // Supervisor-only area refuses a user access
        cycle_req <= '{KIND_CPU, 1'b1, 1'b0};
        area_hit <= 4'hf; cycle_start <= 1;
        @(posedge clock);
        cycle_start <= 0;
        len = 0;
        repeat (10) begin
            @(posedge clock);
            len += violation === 1'b1 ? 1 : (cycle_done === 1'b1 ? 10 : 0);
        end
        chk("violation", len, 1);
        wb(1, AREA3_IDX, 16'hffff);
        wb(0, AREA3_IDX, 0);
        chk("reserved bits", q, AREA_WR_MASK);
        wb(1, 16'h0123, 16'h1234);
        wb(0, 16'h0123, 0);
        chk("unmapped", q, 0);
        // Software keeps code off area tops and the running area unchanged
        wb(1, AREA0_IDX, 16'h0002);
        wb(1, AREA1_IDX, 16'h0005);
        wb(1, AREA3_IDX, 16'h0000);
        foreach (rows[i]) begin
            wb(1, MEMCTL_IDX, rows[i].memctl);
            chk("refresh cfg", refresh_cfg, rows[i].memctl[11:3]);
            run(rows[i], len, code);
            chk("cycle length", len, rows[i].len);
            if (!rows[i].ram) chk("area code", code, rows[i].code);
        end
        soft_reset <= 1;
        @(posedge clock);
        soft_reset <= 0;
        wb(0, AREA0_IDX, 0);
        chk("soft reset area", q, 16'h0002);
        wb(0, MEMCTL_IDX, 0);
        chk("soft reset mem ctrl", q, 16'h0000);
        ext_run(16'h0081, 2);
        ext_run(16'h0080, 1);
        ext_run(16'h0003, 0);
        end_of_test();
    end
endmodule // bus_wait_state_controller_tb
